// ---- src/cpu_register_file.v ----
// Programmer-visible register set of an 8-bit core with an AHB-Lite slave.
// Assumes the execution logic shares clk and issues at most one op a cycle;
// memory answers vector reads on the same clock.
//
// Summary of operation
// - Accumulator feeds the ALU and keeps its value through reset.
// - Reset clears the upper index byte; the low index byte is kept.
// - Index pair forms a 16-bit pointer, upper byte high.
// - Low index byte supports clear, inc, dec, com, neg, shifts, transfers.
// - Stack pointer addresses next free slot; reset forces 0x00FF.
// - Stack adjust adds a sign-extended 8-bit immediate to the pointer.
// - Stack low reinit changes only the pointer's low byte.
// - Fetch pointer increments per fetch; flow changes load it instead.
// - After reset the fetch pointer loads the vector at FFFE and FFFF.
// - Flag bits 6 and 5 always read as one.
// - Bit 7 flags two's complement overflow for signed branches.
// - Bit 4 flags carry from bit 3 into bit 4 on additions.
// - BCD fix uses half carry and carry to correct an addition.
// - Bit 3 set blocks maskable interrupts; clear allows them.
// - Interrupt entry sets the mask after stacking, before service code.
// - No interrupt at the boundary right after a mask clear or flag load that clears a set mask.
// - Bit 2 set when a result or loaded or stored value has its top bit set (bit 15 on the index pair load); transfers leave it.
// - Bit 1 set when a result or loaded or stored value is all zeros; transfers leave it.
// - Bit 0 holds carry or borrow; shifts and bit tests update it.
// - ALU results write back to the accumulator; it loads and stores.
`timescale 1ns/10ps
`include "cpu_regs_consts.vh"

module cpu_register_file (
  input wire clk,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire [5:0] opCode,
  input wire [15:0] opData,
  input wire fetchStep,
  input wire flowLoad,
  input wire [15:0] flowAddr,
  input wire instrBoundary,
  input wire irqPending,
  output wire irqTake,
  output reg [15:0] vecAddr,
  output reg vecRead,
  input wire [7:0] memData,
  input wire memValid,
  output reg coreRun,
  output wire [7:0] aluOperand,
  output wire [15:0] indexPtr,
  output wire [15:0] stackPtr,
  output wire [15:0] fetchPtr,
  output wire [7:0] flagsOut
);

  localparam ST_VEC_HI = 2'b00;
  localparam ST_VEC_LO = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [7:0] workingReg;
  reg [7:0] upperByte;
  reg [7:0] lowByte;
  reg [15:0] stackTop;
  reg [15:0] fetchReg;
  reg flagV;
  reg flagH;
  reg flagI;
  reg flagN;
  reg flagZ;
  reg flagC;
  reg irqInhibit;
  reg [1:0] state;
  reg [7:0] vecHigh;
  reg rdPend;
  reg wrPend;
  reg [7:0] busAddr;

  reg [7:0] next_acc;
  reg [7:0] next_low;
  reg [7:0] next_upper;
  reg [15:0] next_stack;
  reg next_v;
  reg next_h;
  reg next_i;
  reg next_n;
  reg next_z;
  reg next_c;
  reg next_inhibit;
  reg [10:0] sum;
  reg [7:0] res;
  reg [7:0] corr;

  wire [7:0] flagByte;
  wire addrPhase;

  // {overflow, half carry, carry, result}; sub flags borrow in carry
  function [10:0] addSub;
    input [7:0] a;
    input [7:0] b;
    input cin;
    input isSub;
    reg [8:0] full;
    reg [4:0] half;
    reg [7:0] bb;
    begin
      bb = isSub ? ~b : b;
      full = {1'b0, a} + {1'b0, bb} + {8'h00, isSub ^ cin};
      half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, isSub ^ cin};
      addSub = {(a[7] == bb[7]) && (full[7] != a[7]), half[4],
        full[8] ^ isSub, full[7:0]};
    end
  endfunction

  // Register read mux for the bus
  function [31:0] readMux;
    input [7:0] ofs;
    begin
      case (ofs)
        `OFS_ACC: readMux = {24'h000000, workingReg};
        `OFS_INDEX: readMux = {16'h0000, upperByte, lowByte};
        `OFS_STACK: readMux = {16'h0000, stackTop};
        `OFS_FETCH: readMux = {16'h0000, fetchReg};
        `OFS_FLAGS: readMux = {24'h000000, flagByte};
        default: readMux = 32'h00000000;
      endcase
    end
  endfunction

  assign flagByte = {flagV, 1'b1, 1'b1, flagH, flagI, flagN, flagZ,
    flagC};
  assign aluOperand = workingReg;
  assign indexPtr = {upperByte, lowByte};
  assign stackPtr = stackTop;
  assign fetchPtr = fetchReg;
  assign flagsOut = flagByte;
  // Mask and post mask-clear shadow both gate the take
  assign irqTake = coreRun & instrBoundary & irqPending & ~flagI
    & ~irqInhibit;

  // One wait state on reads so the answer sees a preceding write
  assign hreadyout = ~rdPend;
  assign hresp = 1'b0;
  assign addrPhase = hsel & htrans[1] & hready;

  always @* begin
    next_acc = workingReg;
    next_low = lowByte;
    next_upper = upperByte;
    next_stack = stackTop;
    next_v = flagV;
    next_h = flagH;
    next_i = flagI;
    next_n = flagN;
    next_z = flagZ;
    next_c = flagC;
    next_inhibit = irqInhibit;
    sum = 11'h000;
    res = 8'h00;
    corr = 8'h00;
    if (instrBoundary)
      next_inhibit = 1'b0;
    case (opCode)
      `OP_LDA, `OP_STA, `OP_TXA: begin
        if (opCode == `OP_LDA)
          res = opData[7:0];
        else if (opCode == `OP_TXA)
          res = lowByte;
        else
          res = workingReg;
        next_acc = res;
        if (opCode != `OP_TXA) begin
          next_n = res[7];
          next_z = (res == 8'h00);
          next_v = 1'b0;
        end
      end
      `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC: begin
        sum = addSub(workingReg, opData[7:0],
          (opCode == `OP_ADC || opCode == `OP_SBC) & flagC,
          opCode == `OP_SUB || opCode == `OP_SBC);
        next_acc = sum[7:0];
        next_v = sum[10];
        if (opCode == `OP_ADD || opCode == `OP_ADC)
          next_h = sum[9];
        next_c = sum[8];
        next_n = sum[7];
        next_z = (sum[7:0] == 8'h00);
      end
      `OP_AND, `OP_ORA, `OP_EOR: begin
        if (opCode == `OP_AND)
          res = workingReg & opData[7:0];
        else if (opCode == `OP_ORA)
          res = workingReg | opData[7:0];
        else
          res = workingReg ^ opData[7:0];
        next_acc = res;
        next_v = 1'b0;
        next_n = res[7];
        next_z = (res == 8'h00);
      end
      `OP_LDX: begin
        next_low = opData[7:0];
        next_v = 1'b0;
        next_n = opData[7];
        next_z = (opData[7:0] == 8'h00);
      end
      `OP_TAX:
        next_low = workingReg;
      `OP_CLRX, `OP_INCX, `OP_DECX, `OP_COMX, `OP_NEGX: begin
        case (opCode)
          `OP_CLRX: res = 8'h00;
          `OP_INCX: res = lowByte + 8'h01;
          `OP_DECX: res = lowByte - 8'h01;
          `OP_COMX: res = ~lowByte;
          default: res = 8'h00 - lowByte;
        endcase
        next_low = res;
        next_n = res[7];
        next_z = (res == 8'h00);
        case (opCode)
          `OP_INCX: next_v = (lowByte == 8'h7F);
          `OP_DECX: next_v = (lowByte == 8'h80);
          `OP_NEGX: next_v = (res == 8'h80);
          default: next_v = 1'b0;
        endcase
        if (opCode == `OP_COMX)
          next_c = 1'b1;
        else if (opCode == `OP_NEGX)
          next_c = (res != 8'h00);
      end
      `OP_LSLX, `OP_LSRX, `OP_ROLX, `OP_RORX, `OP_ASRX: begin
        case (opCode)
          `OP_LSLX: res = {lowByte[6:0], 1'b0};
          `OP_LSRX: res = {1'b0, lowByte[7:1]};
          `OP_ROLX: res = {lowByte[6:0], flagC};
          `OP_RORX: res = {flagC, lowByte[7:1]};
          default: res = {lowByte[7], lowByte[7:1]};
        endcase
        next_low = res;
        if (opCode == `OP_LSLX || opCode == `OP_ROLX)
          next_c = lowByte[7];
        else
          next_c = lowByte[0];
        next_n = res[7];
        next_z = (res == 8'h00);
        next_v = res[7] ^ next_c;
      end
      `OP_STK_ADJ:
        next_stack = stackTop + {{8{opData[7]}}, opData[7:0]};
      `OP_STK_LOW:
        next_stack = {stackTop[15:8], `STK_LOW_VAL};
      `OP_BCD_FIX: begin
        // Correction picked from carry, half carry, the low nibble and the whole byte
        if (flagC || workingReg > 8'h99) begin
          corr[7:4] = 4'h6;
          next_c = 1'b1;
        end
        if (flagH || workingReg[3:0] > 4'h9)
          corr[3:0] = 4'h6;
        res = workingReg + corr;
        next_acc = res;
        next_n = res[7];
        next_z = (res == 8'h00);
      end
      `OP_MASK_CLR: begin
        next_i = 1'b0;
        next_inhibit = flagI;
      end
      `OP_SEI:
        next_i = 1'b1;
      `OP_TAP: begin
        next_v = workingReg[`FLG_V];
        next_h = workingReg[`FLG_H];
        next_i = workingReg[`FLG_I];
        next_n = workingReg[`FLG_N];
        next_z = workingReg[`FLG_Z];
        next_c = workingReg[`FLG_C];
        next_inhibit = flagI & ~workingReg[`FLG_I];
      end
      `OP_TPA:
        next_acc = flagByte;
      `OP_LDHX: begin
        next_upper = opData[15:8];
        next_low = opData[7:0];
        next_v = 1'b0;
        next_n = opData[15];
        next_z = (opData == 16'h0000);
      end
      // Issued by execution once the stack pushes are done
      `OP_INTMASK:
        next_i = 1'b1;
      `OP_CBIT:
        next_c = opData[0];
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // Accumulator and low index byte: never reset, contents survive
  always @(posedge clk) begin
    if (wrPend && busAddr == `OFS_ACC)
      workingReg <= hwdata[7:0];
    else if (coreRun && rst_b)
      workingReg <= next_acc;
    if (wrPend && busAddr == `OFS_INDEX)
      lowByte <= hwdata[7:0];
    else if (coreRun && rst_b)
      lowByte <= next_low;
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      upperByte <= `RST_UPPER;
      stackTop <= `RST_STACK;
      flagV <= 1'b0;
      flagH <= 1'b0;
      flagI <= `RST_MASK;
      flagN <= 1'b0;
      flagZ <= 1'b0;
      flagC <= 1'b0;
      irqInhibit <= 1'b0;
    end else if (wrPend) begin
      // Bus write wins over a core op in the same cycle
      if (busAddr == `OFS_INDEX)
        upperByte <= hwdata[15:8];
      if (busAddr == `OFS_STACK)
        stackTop <= hwdata[15:0];
      if (busAddr == `OFS_FLAGS) begin
        flagV <= hwdata[`FLG_V];
        flagH <= hwdata[`FLG_H];
        flagI <= hwdata[`FLG_I];
        flagN <= hwdata[`FLG_N];
        flagZ <= hwdata[`FLG_Z];
        flagC <= hwdata[`FLG_C];
      end
    end else if (coreRun) begin
      upperByte <= next_upper;
      stackTop <= next_stack;
      flagV <= next_v;
      flagH <= next_h;
      flagI <= next_i;
      flagN <= next_n;
      flagZ <= next_z;
      flagC <= next_c;
      irqInhibit <= next_inhibit;
    end
  end

  // Vector fetch after reset, then fetch pointer stepping
  always @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_VEC_HI;
      vecAddr <= `VEC_HI_ADDR;
      vecRead <= 1'b1;
      vecHigh <= 8'h00;
      coreRun <= 1'b0;
      fetchReg <= 16'h0000;
    end else begin
      case (state)
        ST_VEC_HI: begin
          if (memValid) begin
            vecHigh <= memData;
            vecAddr <= `VEC_LO_ADDR;
            state <= ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (memValid) begin
            fetchReg <= {vecHigh, memData};
            vecRead <= 1'b0;
            coreRun <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wrPend && busAddr == `OFS_FETCH)
            fetchReg <= hwdata[15:0];
          else if (flowLoad)
            fetchReg <= flowAddr;
          else if (fetchStep)
            fetchReg <= fetchReg + 16'h0001;
        end
        default:
          state <= ST_VEC_HI;
      endcase
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  always @(posedge clk) begin
    if (!rst_b) begin
      rdPend <= 1'b0;
      wrPend <= 1'b0;
      busAddr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      if (rdPend)
        hrdata <= readMux(busAddr);
      rdPend <= addrPhase & ~hwrite;
      wrPend <= addrPhase & hwrite;
      if (addrPhase)
        busAddr <= haddr[7:0];
    end
  end

endmodule

// ---- src/cpu_regs_consts.vh ----
// Constants for the processor register file: bus offsets, reset values,
// operation codes and flag positions. Definitions only.
`ifndef CPU_REGS_CONSTS_VH
`define CPU_REGS_CONSTS_VH

// Bus offsets, one aligned word each
`define OFS_ACC 8'h00
`define OFS_INDEX 8'h04
`define OFS_STACK 8'h08
`define OFS_FETCH 8'h0C
`define OFS_FLAGS 8'h10

// Reset values, stack low reinit byte and vector addresses
`define RST_UPPER 8'h00
`define RST_STACK 16'h00FF
`define STK_LOW_VAL 8'hFF
`define RST_MASK 1'b1
`define VEC_HI_ADDR 16'hFFFE
`define VEC_LO_ADDR 16'hFFFF

// Flag bit positions
`define FLG_V 7
`define FLG_ONE6 6
`define FLG_ONE5 5
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0

// Operation codes from the execution logic
`define OP_NONE 6'h00
`define OP_LDA 6'h01
`define OP_STA 6'h02
`define OP_ADD 6'h03
`define OP_ADC 6'h04
`define OP_SUB 6'h05
`define OP_SBC 6'h06
`define OP_AND 6'h07
`define OP_ORA 6'h08
`define OP_EOR 6'h09
`define OP_LDX 6'h0A
`define OP_TAX 6'h0B
`define OP_TXA 6'h0C
`define OP_CLRX 6'h0D
`define OP_INCX 6'h0E
`define OP_DECX 6'h0F
`define OP_COMX 6'h10
`define OP_NEGX 6'h11
`define OP_LSLX 6'h12
`define OP_LSRX 6'h13
`define OP_ROLX 6'h14
`define OP_RORX 6'h15
`define OP_ASRX 6'h16
`define OP_STK_ADJ 6'h17
`define OP_STK_LOW 6'h18
`define OP_BCD_FIX 6'h19
`define OP_MASK_CLR 6'h1A
`define OP_SEI 6'h1B
`define OP_TAP 6'h1C
`define OP_TPA 6'h1D
`define OP_LDHX 6'h1E
`define OP_INTMASK 6'h1F
`define OP_CBIT 6'h20

`endif

// ---- verification/cpu_register_file_tb.sv ----
// Testbench: register file over AHB-Lite and the core op port.
// Assumes the vector memory model answers the reset vector fetch.
`timescale 1ns/10ps
`include "cpu_regs_consts.vh"
module cpu_register_file_tb;
  localparam [15:0] VEC = 16'hC3A5;
  reg clk, rst_b, hsel, hwrite, fetchStep, flowLoad, instrBoundary;
  reg irqPending, slow;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, rd, rnd;
  reg [5:0] opCode, k;
  reg [15:0] opData, flowAddr, stk, e;
  reg [7:0] a, x;
  integer errorCnt, numChecks, i, n;
  wire hreadyout, hresp, irqTake, vecRead, memValid, coreRun;
  wire [31:0] hrdata;
  wire [15:0] vecAddr, indexPtr, stackPtr, fetchPtr;
  wire [7:0] memData, aluOperand, flagsOut;

  cpu_register_file cpu_register_file_i (.*, .hsize(3'h2),
    .hready(hreadyout));
  vector_mem_model #(.VECTOR(VEC)) vector_mem_model_i (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  function [15:0] addExp(input [7:0] p, input [7:0] q);
    reg [8:0] s;
    reg [4:0] h;
    s = p + q;
    h = p[3:0] + q[3:0];
    addExp = {p[7] == q[7] && s[7] != p[7], 2'b11, h[4], 1'b0,
      s[7], s[7:0] == 8'h00, s[8], s[7:0]};
  endfunction

  function [7:0] daaExp(input [7:0] v, input hc, input cc);
    reg [7:0] t;
    t = (hc || v[3:0] > 4'h9) ? 8'h06 : 8'h00;
    if (cc || v > 8'h99) t = t | 8'h60;
    daaExp = v + t;
  endfunction

  function [8:0] xExp(input [5:0] c, input [7:0] v, input ci);
    case (c)
      `OP_CLRX: xExp = {ci, 8'h00};
      `OP_INCX: xExp = {ci, v + 8'h01};
      `OP_DECX: xExp = {ci, v - 8'h01};
      `OP_COMX: xExp = {ci, ~v};
      `OP_NEGX: xExp = {ci, 8'h00 - v};
      `OP_LSLX: xExp = {v, 1'b0};
      `OP_LSRX: xExp = {v[0], 1'b0, v[7:1]};
      `OP_ROLX: xExp = {v, ci};
      `OP_RORX: xExp = {v[0], ci, v[7:1]};
      default: xExp = {v[0], v[7], v[7:1]};
    endcase
  endfunction

  function [31:0] regExp(input [7:0] ad, input [31:0] d);
    case (ad)
      `OFS_ACC: regExp = {24'h000000, d[7:0]};
      `OFS_INDEX, `OFS_STACK, `OFS_FETCH: regExp = {16'h0000, d[15:0]};
      `OFS_FLAGS: regExp = {24'h000000, d[7], 2'b11, d[4:0]};
      default: regExp = 32'h00000000;
    endcase
  endfunction

  task check(input string nm, input [31:0] ex, input [31:0] got);
    numChecks = numChecks + 1;
    if (got !== ex) begin
      errorCnt = errorCnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task stopTest;
    $display("Checks %0d, mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Sampled before the edge, so the master sees what the slave settled
  task waitRdy;
    do @(negedge clk); while (hreadyout !== 1'b1);
  endtask

  task bus(input w, input [7:0] ad, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, ad};
    waitRdy;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    rd = hrdata;
    @(posedge clk);
  endtask

  task op(input [5:0] c, input [15:0] d);
    @(posedge clk);
    opCode <= c;
    opData <= d;
    @(posedge clk);
    opCode <= `OP_NONE;
    @(negedge clk);
  endtask

  task bound(input ex);
    @(posedge clk);
    instrBoundary <= 1'b1;
    @(negedge clk);
    check("irqTake", ex, irqTake);
    @(posedge clk);
    instrBoundary <= 1'b0;
  endtask

  task bcdCase(input [7:0] p, input [7:0] q);
    op(`OP_LDA, {8'h00, p});
    op(`OP_ADD, {8'h00, q});
    e = addExp(p, q);
    op(`OP_BCD_FIX, 16'h0000);
    check("bcd", daaExp(e[7:0], e[12], e[8]), aluOperand);
  endtask

  task doReset(input s);
    @(posedge clk);
    slow <= s;
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    i = 0;
    while (coreRun !== 1'b1 && i < 50) begin
      @(negedge clk);
      i = i + 1;
    end
    check("coreRun", 1'b1, coreRun);
    check("fetchPtr", VEC, fetchPtr);
    check("stackPtr", 16'h00FF, stackPtr);
    check("upperIdx", 8'h00, indexPtr[15:8]);
    check("flags", 8'h68, flagsOut);
  endtask

  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    errorCnt = errorCnt + 1;
    stopTest;
  end

  initial begin
    {hsel, hwrite, fetchStep, flowLoad, instrBoundary, irqPending} = 6'h00;
    {htrans, haddr, hwdata, opCode, opData, flowAddr} = '0;
    {rst_b, slow, errorCnt, numChecks} = '0;
    rnd = 32'h8C55A632;
    doReset(1'b0);
    $display("Vector load done");
    for (n = 0; n < 6; n = n + 1) begin
      rnd = lfsr(rnd);
      bus(1'b1, {n[5:0], 2'b00}, rnd);
      bus(1'b0, {n[5:0], 2'b00}, 32'h00000000);
      check("busReg", regExp({n[5:0], 2'b00}, rnd), rd);
    end
    $display("Register bus done");
    for (n = 0; n < 8; n = n + 1) begin
      rnd = lfsr(rnd);
      a = (n == 0) ? 8'h80 : rnd[7:0];
      x = (n == 0) ? 8'h80 : rnd[15:8];
      op(`OP_LDA, {8'h00, a});
      check("loadNZ", {a[7], a == 8'h00}, flagsOut[2:1]);
      op(`OP_ADD, {8'h00, x});
      e = addExp(a, x);
      check("sum", e[7:0], aluOperand);
      check("addFlags", e[15:8], flagsOut & 8'hF7);
      bcdCase({1'b0, rnd[18:16], 1'b0, rnd[22:20]},
        {1'b0, rnd[26:24], 1'b0, rnd[30:28]});
    end
    bcdCase(8'h99, 8'h01);
    $display("Arithmetic done");
    for (k = `OP_CLRX; k <= `OP_ASRX; k = k + 6'h01) begin
      rnd = lfsr(rnd);
      op(`OP_LDX, {8'h00, rnd[7:0]});
      op(`OP_CBIT, {15'h0000, rnd[8]});
      op(k, 16'h0000);
      e = {7'h00, xExp(k, rnd[7:0], rnd[8])};
      check("xData", e[7:0], indexPtr[7:0]);
      check("xNZ", {e[7], e[7:0] == 8'h00}, flagsOut[2:1]);
      if (k >= `OP_LSLX) check("xCarry", e[8], flagsOut[0]);
    end
    op(`OP_TXA, 16'h0000);
    check("txa", e[7:0], aluOperand);
    $display("Index ops done");
    op(`OP_LDHX, rnd[31:16]);
    check("indexPair", rnd[31:16], indexPtr);
    stk = {8'h12, rnd[23:16]};
    bus(1'b1, `OFS_STACK, {16'h0000, stk});
    for (n = 0; n < 3; n = n + 1) begin
      a = (n == 0) ? 8'h80 : (n == 1) ? 8'h7F : rnd[15:8];
      op(`OP_STK_ADJ, {8'h00, a});
      stk = stk + {{8{a[7]}}, a};
      check("stackAdj", stk, stackPtr);
    end
    op(`OP_STK_LOW, 16'h0000);
    check("stackLow", {stk[15:8], 8'hFF}, stackPtr);
    bus(1'b1, `OFS_FETCH, 32'h0000FFFF);
    @(posedge clk);
    fetchStep <= 1'b1;
    flowAddr <= rnd[15:0];
    repeat (2) @(posedge clk);
    flowLoad <= 1'b1;
    @(negedge clk);
    check("fetchStep", 16'h0001, fetchPtr);
    @(posedge clk);
    {fetchStep, flowLoad} <= 2'b00;
    @(negedge clk);
    check("flowLoad", rnd[15:0], fetchPtr);
    $display("Pointers done");
    @(posedge clk);
    irqPending <= 1'b1;
    op(`OP_SEI, 16'h0000);
    bound(1'b0);
    op(`OP_MASK_CLR, 16'h0000);
    bound(1'b0);
    bound(1'b1);
    op(`OP_INTMASK, 16'h0000);
    bound(1'b0);
    op(`OP_LDA, 16'h0000);
    op(`OP_TAP, 16'h0000);
    bound(1'b0);
    bound(1'b1);
    op(`OP_TPA, 16'h0000);
    check("flagsToA", 8'h60, aluOperand);
    $display("Interrupt mask done");
    op(`OP_LDHX, {8'h33, rnd[7:0]});
    op(`OP_LDA, {8'h00, rnd[15:8]});
    doReset(1'b1);
    check("keepA", rnd[15:8], aluOperand);
    check("keepX", rnd[7:0], indexPtr);
    $display("Second reset done");
    stopTest;
  end
endmodule

// ---- verification/cpu_regs_chk.sv ----
// Checker: timing relations on the register file's ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`include "cpu_regs_consts.vh"
module cpu_regs_chk (
  input wire clk,
  input wire rst_b,
  input wire [5:0] opCode,
  input wire [15:0] opData,
  input wire fetchStep,
  input wire flowLoad,
  input wire [15:0] flowAddr,
  input wire instrBoundary,
  input wire irqTake,
  input wire [15:0] vecAddr,
  input wire vecRead,
  input wire [7:0] memData,
  input wire memValid,
  input wire coreRun,
  input wire [7:0] aluOperand,
  input wire [15:0] indexPtr,
  input wire [15:0] stackPtr,
  input wire [15:0] fetchPtr,
  input wire [7:0] flagsOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reset checks must see the reset itself, so no disable
  a_reset_keep: assert property (disable iff (1'b0)
    !rst_b && coreRun |=> aluOperand == $past(aluOperand) &&
    indexPtr == {8'h00, $past(indexPtr[7:0])})
    else $error("reset disturbed A or X");
  a_reset_vals: assert property (disable iff (1'b0)
    !rst_b |=> stackPtr == `RST_STACK && indexPtr[15:8] == 8'h00)
    else $error("stack or upper byte not reset");
  a_ones_bits: assert property (flagsOut[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  a_fetch_step: assert property (
    coreRun && fetchStep && !flowLoad |=> fetchPtr == $past(fetchPtr) + 16'h1)
    else $error("fetch pointer did not step");
  a_flow_load: assert property (
    coreRun && flowLoad |=> fetchPtr == $past(flowAddr))
    else $error("flow load not taken");
  a_vector_load: assert property (
    vecRead && memValid && vecAddr == `VEC_LO_ADDR |=>
    coreRun && !vecRead && fetchPtr[7:0] == $past(memData))
    else $error("vector low byte not loaded");
  a_stack_adjust: assert property (
    coreRun && opCode == `OP_STK_ADJ |=> stackPtr == $past(stackPtr) +
    {{8{$past(opData[7])}}, $past(opData[7:0])})
    else $error("stack adjust wrong");
  a_low_reinit: assert property (
    coreRun && opCode == `OP_STK_LOW |=>
    stackPtr == {$past(stackPtr[15:8]), `STK_LOW_VAL})
    else $error("stack reinit wrong");
  a_mask_blocks: assert property (irqTake |-> !flagsOut[`FLG_I])
    else $error("interrupt taken while masked");
  a_cli_shadow: assert property (
    coreRun && opCode == `OP_MASK_CLR && flagsOut[`FLG_I] ##1 !instrBoundary
    ##1 instrBoundary |-> !irqTake)
    else $error("interrupt right after mask clear");
  c_vector: cover property (vecRead && memValid && vecAddr == `VEC_LO_ADDR);
  c_irq: cover property (irqTake);
  c_stack_neg: cover property (coreRun && opCode == `OP_STK_ADJ && opData[7]);
endmodule

bind cpu_register_file cpu_regs_chk cpu_regs_chk_i (.*);

// ---- verification/vector_mem_model.sv ----
// Memory side model: answers the core's reset vector byte reads.
// Assumes vecRead and vecAddr hold until a byte is taken.
`timescale 1ns/10ps
module vector_mem_model #(
  parameter [15:0] VECTOR = 16'hC3A5
) (
  input wire clk,
  input wire vecRead,
  input wire [15:0] vecAddr,
  input wire slow,
  output reg [7:0] memData,
  output reg memValid
);
  reg [2:0] waitCnt;
  initial {memData, memValid, waitCnt} = 12'h000;
  always @(posedge clk) begin
    memValid <= 1'b0;
    // Released data lines toggle so a stale byte never looks valid
    memData <= ~memData;
    if (vecRead && !memValid && waitCnt >= (slow ? 3'h3 : 3'h0)) begin
      memValid <= 1'b1;
      // High byte at the lower address
      memData <= (vecAddr == 16'hFFFE) ? VECTOR[15:8] : VECTOR[7:0];
      waitCnt <= 3'h0;
    end else if (vecRead) begin
      waitCnt <= waitCnt + 3'h1;
    end
  end
endmodule
